// file: common/accu_consts.vh
/*
  constants for the accumulator convert and substitute unit:
  operation codes, parameter word fields, system word window.
  assumes nothing; definitions only.
*/
`ifndef ACCU_CONSTS_VH
`define ACCU_CONSTS_VH

`define OP_W 5
`define OP_NONE 5'h00
`define OP_ONES_LOW 5'h01
`define OP_NEG_LOW 5'h02
`define OP_NEG_32 5'h03
`define OP_BCD_BIN16 5'h04
`define OP_BIN16_BCD 5'h05
`define OP_BCD_BIN32 5'h06
`define OP_BIN32_BCD 5'h07
`define OP_INT_FLOAT 5'h08
`define OP_FLOAT_INT 5'h09
`define OP_DEC_BYTE 5'h0A
`define OP_INC_BYTE 5'h0B
`define OP_SUB_BLOCK 5'h0C
`define OP_SUB_MARKER 5'h0D
`define OP_SUB_FORMAL 5'h0E
`define OP_FORMAL_RUN 5'h0F
`define OP_SYS_RUN 5'h10
`define OP_INT_MASK 5'h11
`define OP_INT_UNMASK 5'h12
`define OP_LOAD 5'h13

`define KIND_W 3
`define KIND_OTHER 3'h0
`define KIND_MARKER_BIT 3'h1
`define KIND_SYS_FLAG 3'h2
`define KIND_TIMER_CNT 3'h3
`define KIND_BLOCK_CALL 3'h4

`define MB_BYTE_HI 7
`define MB_BIT_LO 8
`define MB_BIT_HI 10
`define SF_BYTE_HI 11
`define SF_BIT_LO 12
`define SF_BIT_HI 14
`define SF_ZERO_BIT 15
`define TC_CELL_HI 7

`define SYS_WORD_FIRST 8'h3C
`define SYS_WORD_LAST 8'h3F
`define MARKER_WORD_LAST 8'hFE

`define ACC_RESET 32'h00000000
`define FLOAT_BIAS 8'h7F

`endif

// file: rtl/bcd_convert.v
/*
  combinational bcd <-> binary for 16 and 32 bit fields.
  assumes valid bcd digits on bcd input; invalid digits give no error.
*/
`timescale 1ns/10ps
`default_nettype none
module bcd_convert (
  input wire [31:0] value,
  output reg [31:0] bcd_to_bin,
  output reg [31:0] bin_to_bcd
);
  integer i;
  reg [31:0] acc;
  reg [63:0] sh;
  always @* begin
    acc = 32'h00000000;
    for (i = 7; i >= 0; i = i - 1) begin
      acc = acc * 32'd10 + {28'h0000000, value[i*4 +: 4]};
    end
    bcd_to_bin = acc;
    // double dabble; high digits beyond 8 are dropped, value capped by width
    sh = {32'h00000000, value};
    for (i = 0; i < 32; i = i + 1) begin
      if (sh[35:32] > 4'h4) sh[35:32] = sh[35:32] + 4'h3;
      if (sh[39:36] > 4'h4) sh[39:36] = sh[39:36] + 4'h3;
      if (sh[43:40] > 4'h4) sh[43:40] = sh[43:40] + 4'h3;
      if (sh[47:44] > 4'h4) sh[47:44] = sh[47:44] + 4'h3;
      if (sh[51:48] > 4'h4) sh[51:48] = sh[51:48] + 4'h3;
      if (sh[55:52] > 4'h4) sh[55:52] = sh[55:52] + 4'h3;
      if (sh[59:56] > 4'h4) sh[59:56] = sh[59:56] + 4'h3;
      if (sh[63:60] > 4'h4) sh[63:60] = sh[63:60] + 4'h3;
      sh = {sh[62:0], 1'b0};
    end
    bin_to_bcd = sh[63:32];
  end
endmodule // bcd_convert
`default_nettype wire

// file: rtl/float_convert.v
/*
  combinational 32-bit integer <-> float (sign, 8-bit biased exponent, 23-bit mantissa).
  assumes normalised input floats; float to int rounds toward minus infinity, except magnitudes below one give zero.
*/
`timescale 1ns/10ps
`default_nettype none
`include "accu_consts.vh"
module float_convert (
  input wire [31:0] value,
  output reg [31:0] to_float,
  output reg [31:0] to_int
);
  integer i;
  integer msb;
  reg [31:0] mag;
  reg [31:0] norm;
  reg [7:0] ex;
  reg [55:0] m;
  reg [55:0] sh;
  reg frac;
  always @* begin
    msb = 0;
    mag = value[31] ? (~value + 32'h00000001) : value;
    for (i = 0; i < 32; i = i + 1) begin
      if (mag[i]) msb = i;
    end
    norm = mag << (31 - msb);
    ex = `FLOAT_BIAS + msb[7:0];
    // low mantissa bits truncated; 24-bit precision is the trade
    if (mag == 32'h00000000) to_float = 32'h00000000;
    else to_float = {value[31], ex, norm[30:8]};
    m = {32'h00000000, 1'b1, value[22:0]};
    frac = 1'b0;
    sh = 56'h0;
    if (value[30:23] < `FLOAT_BIAS) begin
      sh = 56'h0;
      frac = (value[30:0] != 31'h0);
    end else if (value[30:23] >= `FLOAT_BIAS + 8'd23) begin
      sh = m << (value[30:23] - `FLOAT_BIAS - 8'd23);
    end else begin
      sh = m >> (`FLOAT_BIAS + 8'd23 - value[30:23]);
      frac = ((sh << (`FLOAT_BIAS + 8'd23 - value[30:23])) != m);
    end
    // magnitudes below one give zero for either sign
    if (value[31] && (value[30:23] >= `FLOAT_BIAS)) to_int = ~sh[31:0] + 32'h00000001 - {31'h0, frac};
    else to_int = sh[31:0];
  end
endmodule // float_convert
`default_nettype wire

// file: rtl/accu_convert_unit.v
/*
  execution unit for accumulator conversion, byte step, operand
  substitution, indirect opcode run and process interrupt masking.
  assumes one operation per op_valid pulse from the instruction sequencer,
  which also supplies fetched data words, flag words and formal operands.
  the sequencer answers each fetch_req with one fetched_valid pulse, after
  any number of cycles; ops offered while a fetch is open are dropped.
  illegal kinds and indexes raise op_error at the taking edge, no fetch.
  op_param and logic_result are accepted but unused: the parameter word
  arrives as a fetched word and the byte step never looks at the result.
  the float format is sign, 8-bit biased exponent and 23-bit mantissa.
  bcd inputs with digits above nine give no error and no defined result.
  substitutions leave the accumulator untouched; only the next non-substitution op sees them.
*/
`timescale 1ns/10ps
`default_nettype none
`include "accu_consts.vh"
// How it works
// - ones_complement_low inverts all 16 low accumulator bits.
// - negate_low_word makes the low word its two's complement.
// - negate_32 makes the full accumulator its two's complement.
// - bcd_to_bin16 reads low 16 bits as bcd, writes binary low word.
// - bin16_to_bcd writes the bcd form of the low word back there.
// - bcd_to_bin32 converts the full accumulator from bcd to binary.
// - bin32_to_bcd converts the full accumulator from binary to bcd.
// - int_to_float gives 32-bit float, sign bit one when negative.
// - float_to_int rounds down; values between minus one and zero give zero.
// - decrement subtracts operand 1..255 from low accumulator byte.
// - increment adds operand 1..255 to low accumulator byte.
// - byte step wraps in the byte and ignores the logic result.
// - block_word substitution feeds data word 0..255 as next operand.
// - marker_word substitution feeds flag word 0..254 as next operand.
// - substitution applies to the next instruction that is not itself a substitution only.
// - formal substitution accepts only block calls; other kinds raise op_error.
// - formal_opcode_run executes opcode from formal operand indexed by accumulator.
// - system word run uses words 60..63, second word from n+1 for 60..62.
// - marker bit parameter: byte bits 7..0, bit 10..8, rest ignored.
// - system flag parameter: byte 11..0, bit 14..12, bit 15 zero.
// - timer and counter parameter: cell in bits 7..0, rest ignored.
// - interrupt_mask_on blocks process interrupts until unmasked.
// - interrupt_unmask restores process interrupt servicing.
// - accumulator is 32 bits; word ops use low half only.
module accu_convert_unit (
  input wire clk,
  input wire reset_n,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] op_operand,
  input wire [15:0] op_param,
  input wire [2:0] op_kind,
  input wire logic_result,
  input wire acc_load_valid,
  input wire [31:0] acc_load_value,
  input wire [15:0] fetched_word,
  input wire fetched_valid,
  input wire process_irq_req,
  output reg [31:0] first_accumulator,
  output reg op_done,
  output reg op_error,
  output reg fetch_req,
  output reg [1:0] fetch_space,
  output reg [7:0] fetch_index,
  output reg subst_active,
  output reg [15:0] subst_value,
  output reg [11:0] subst_byte_addr,
  output reg [2:0] subst_bit_addr,
  output reg exec_valid,
  output reg [15:0] exec_word0,
  output reg [15:0] exec_word1,
  output reg process_irq_service,
  output reg irq_masked
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_FETCH0 = 4'b0010;
  localparam [3:0] S_FETCH1 = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;

  localparam [1:0] SPACE_BLOCK = 2'h0;
  localparam [1:0] SPACE_MARKER = 2'h1;
  localparam [1:0] SPACE_FORMAL = 2'h2;
  localparam [1:0] SPACE_SYSTEM = 2'h3;

  wire [31:0] bcd_bin;
  wire [31:0] bin_bcd;
  wire [31:0] bcd_bin_lo;
  wire [31:0] bin_bcd_lo;
  wire [31:0] fl_out;
  wire [31:0] int_out;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [31:0] acc_d;
  reg pending_q;
  reg pending_d;
  reg [4:0] cur_op_q;
  reg [4:0] cur_op_d;
  reg [7:0] sys_idx_q;
  reg [7:0] sys_idx_d;
  reg [15:0] word0_q;
  reg [15:0] word0_d;

  bcd_convert u_bcd32 (
    .value(first_accumulator),
    .bcd_to_bin(bcd_bin),
    .bin_to_bcd(bin_bcd)
  );

  bcd_convert u_bcd16 (
    .value({16'h0000, first_accumulator[15:0]}),
    .bcd_to_bin(bcd_bin_lo),
    .bin_to_bcd(bin_bcd_lo)
  );

  float_convert u_float (
    .value(first_accumulator),
    .to_float(fl_out),
    .to_int(int_out)
  );

  // substitution fields decoded from the parameter word
  reg [15:0] sv_d;
  reg [11:0] sb_d;
  reg [2:0] sbit_d;
  reg bad_param;
  always @* begin
    sv_d = fetched_word;
    sb_d = 12'h000;
    sbit_d = 3'h0;
    bad_param = 1'b0;
    case (op_kind)
      `KIND_MARKER_BIT: begin
        sb_d = {4'h0, fetched_word[`MB_BYTE_HI:0]};
        sbit_d = fetched_word[`MB_BIT_HI:`MB_BIT_LO];
      end
      `KIND_SYS_FLAG: begin
        sb_d = fetched_word[`SF_BYTE_HI:0];
        sbit_d = fetched_word[`SF_BIT_HI:`SF_BIT_LO];
        bad_param = fetched_word[`SF_ZERO_BIT];
      end
      `KIND_TIMER_CNT: begin
        sb_d = {4'h0, fetched_word[`TC_CELL_HI:0]};
      end
      default: begin
        sb_d = fetched_word[11:0];
      end
    endcase
  end

  wire sub_op = (op_code == `OP_SUB_BLOCK) || (op_code == `OP_SUB_MARKER) ||
    (op_code == `OP_SUB_FORMAL);
  // a second fetch is needed for the two-word system run
  wire sys_two = (sys_idx_q != `SYS_WORD_LAST);
  // refused at the taking edge, so the sequencer never sees a fetch for it
  wire bad_marker = (op_code == `OP_SUB_MARKER) && (op_operand > `MARKER_WORD_LAST);

  always @* begin
    state_d = state_q;
    acc_d = first_accumulator;
    pending_d = pending_q;
    cur_op_d = cur_op_q;
    sys_idx_d = sys_idx_q;
    word0_d = word0_q;
    case (state_q)
      S_IDLE: begin
        if (acc_load_valid) acc_d = acc_load_value;
        if (op_valid) begin
          cur_op_d = op_code;
          // the substitution is spent by the next instruction that is not itself a substitution
          if (!sub_op) pending_d = 1'b0;
          case (op_code)
            `OP_ONES_LOW: acc_d = {first_accumulator[31:16], ~first_accumulator[15:0]};
            `OP_NEG_LOW: acc_d = {first_accumulator[31:16],
              16'h0000 - first_accumulator[15:0]};
            `OP_NEG_32: acc_d = 32'h00000000 - first_accumulator;
            `OP_BCD_BIN16: acc_d = {first_accumulator[31:16], bcd_bin_lo[15:0]};
            `OP_BIN16_BCD: acc_d = {first_accumulator[31:16], bin_bcd_lo[15:0]};
            `OP_BCD_BIN32: acc_d = bcd_bin;
            `OP_BIN32_BCD: acc_d = bin_bcd;
            `OP_INT_FLOAT: acc_d = fl_out;
            `OP_FLOAT_INT: acc_d = int_out;
            // logic_result deliberately unused: byte step is unconditional
            `OP_DEC_BYTE: acc_d = {first_accumulator[31:8],
              first_accumulator[7:0] - op_operand};
            `OP_INC_BYTE: acc_d = {first_accumulator[31:8],
              first_accumulator[7:0] + op_operand};
            `OP_SUB_BLOCK, `OP_SUB_MARKER: begin
              // a marker word above 254 would leave a fetch open forever
              if (bad_marker) state_d = S_DONE;
              else state_d = S_FETCH0;
            end
            `OP_SUB_FORMAL: begin
              if (op_kind == `KIND_BLOCK_CALL) state_d = S_FETCH0;
              else state_d = S_DONE;
            end
            `OP_FORMAL_RUN: state_d = S_FETCH0;
            `OP_SYS_RUN: begin
              sys_idx_d = op_operand;
              if (op_operand >= `SYS_WORD_FIRST && op_operand <= `SYS_WORD_LAST) begin
                state_d = S_FETCH0;
              end else begin
                state_d = S_DONE;
              end
            end
            default: acc_d = first_accumulator;
          endcase
        end
      end
      S_FETCH0: begin
        if (fetched_valid) begin
          word0_d = fetched_word;
          if (cur_op_q == `OP_SUB_BLOCK || cur_op_q == `OP_SUB_MARKER ||
              cur_op_q == `OP_SUB_FORMAL) begin
            pending_d = 1'b1;
            state_d = S_DONE;
          end else if (cur_op_q == `OP_SYS_RUN && sys_two) begin
            state_d = S_FETCH1;
          end else begin
            state_d = S_DONE;
          end
        end
      end
      S_FETCH1: begin
        if (fetched_valid) state_d = S_DONE;
      end
      S_DONE: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      first_accumulator <= `ACC_RESET;
      pending_q <= 1'b0;
      cur_op_q <= `OP_NONE;
      sys_idx_q <= 8'h00;
      word0_q <= 16'h0000;
      op_done <= 1'b0;
      op_error <= 1'b0;
      subst_active <= 1'b0;
      subst_value <= 16'h0000;
      subst_byte_addr <= 12'h000;
      subst_bit_addr <= 3'h0;
    end else begin
      state_q <= state_d;
      first_accumulator <= acc_d;
      pending_q <= pending_d;
      cur_op_q <= cur_op_d;
      sys_idx_q <= sys_idx_d;
      word0_q <= word0_d;
      subst_active <= pending_d;
      op_done <= (state_q == S_IDLE && op_valid && state_d == S_IDLE) ||
        (state_q == S_DONE);
      op_error <= 1'b0;
      if (state_q == S_IDLE && op_valid) begin
        if (op_code == `OP_SUB_FORMAL && op_kind != `KIND_BLOCK_CALL) begin
          op_error <= 1'b1;
        end
        if (op_code == `OP_SYS_RUN &&
            (op_operand < `SYS_WORD_FIRST || op_operand > `SYS_WORD_LAST)) begin
          op_error <= 1'b1;
        end
        if (op_code == `OP_SUB_MARKER && op_operand > `MARKER_WORD_LAST) begin
          op_error <= 1'b1;
        end
      end
      if (state_q == S_FETCH0 && fetched_valid && state_d == S_DONE &&
          cur_op_q != `OP_FORMAL_RUN && cur_op_q != `OP_SYS_RUN) begin
        subst_value <= sv_d;
        subst_byte_addr <= sb_d;
        subst_bit_addr <= sbit_d;
        if (bad_param) op_error <= 1'b1;
      end
    end
  end

  // fetch side flops: request level, space and index
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_req <= 1'b0;
      fetch_space <= 2'h0;
      fetch_index <= 8'h00;
    end else begin
      fetch_req <= (state_d == S_FETCH0 || state_d == S_FETCH1);
      if (state_q == S_IDLE && op_valid) begin
        case (op_code)
          `OP_SUB_MARKER: fetch_space <= SPACE_MARKER;
          `OP_SUB_FORMAL: fetch_space <= SPACE_FORMAL;
          `OP_FORMAL_RUN: fetch_space <= SPACE_FORMAL;
          `OP_SYS_RUN: fetch_space <= SPACE_SYSTEM;
          default: fetch_space <= SPACE_BLOCK;
        endcase
        // formal run indexes by the accumulator, not the operand
        if (op_code == `OP_FORMAL_RUN) fetch_index <= first_accumulator[7:0];
        else fetch_index <= op_operand;
      end else if (state_q == S_FETCH0 && fetched_valid && state_d == S_FETCH1) begin
        fetch_index <= sys_idx_q + 8'h01;
      end
    end
  end

  // opcode words for the sequencer; they stand until the next run
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_valid <= 1'b0;
      exec_word0 <= 16'h0000;
      exec_word1 <= 16'h0000;
    end else begin
      exec_valid <= 1'b0;
      if (state_q == S_FETCH0 && fetched_valid && state_d == S_DONE &&
          (cur_op_q == `OP_FORMAL_RUN || cur_op_q == `OP_SYS_RUN)) begin
        exec_valid <= 1'b1;
        exec_word0 <= fetched_word;
        exec_word1 <= 16'h0000;
      end
      if (state_q == S_FETCH1 && fetched_valid) begin
        exec_valid <= 1'b1;
        exec_word0 <= word0_q;
        exec_word1 <= fetched_word;
      end
    end
  end

  // masking flops; nothing else in the unit reads them
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      process_irq_service <= 1'b0;
      irq_masked <= 1'b0;
    end else begin
      if (state_q == S_IDLE && op_valid && op_code == `OP_INT_MASK) begin
        irq_masked <= 1'b1;
      end else if (state_q == S_IDLE && op_valid && op_code == `OP_INT_UNMASK) begin
        irq_masked <= 1'b0;
      end
      process_irq_service <= process_irq_req && !irq_masked;
    end
  end
endmodule // accu_convert_unit
`default_nettype wire

// file: tb/accu_convert_unit_props.sv
/*
  port checker for accu_convert_unit, bound to every instance.
  assumes one clock, and that ops are only issued while the unit is idle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "accu_consts.vh"
module accu_convert_unit_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] op_operand,
  input wire logic [15:0] fetched_word,
  input wire logic fetched_valid,
  input wire logic process_irq_req,
  input wire logic [31:0] first_accumulator,
  input wire logic op_done,
  input wire logic op_error,
  input wire logic fetch_req,
  input wire logic [1:0] fetch_space,
  input wire logic [7:0] fetch_index,
  input wire logic subst_active,
  input wire logic [15:0] subst_value,
  input wire logic process_irq_service,
  input wire logic irq_masked
);
  logic busy_q;
  wire take = op_valid && !busy_q;
  wire [31:0] acc = first_accumulator;
  wire [15:0] hi_w = acc[31:16];
  wire [15:0] lo_w = acc[15:0];
  wire [23:0] mid_w = acc[31:8];
  wire [7:0] byte_w = acc[7:0];
  // fetch ops hold the unit; ops offered meanwhile are dropped, so not counted
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_q <= 1'h0;
    else if (op_done || op_error) busy_q <= 1'h0;
    else if (take && op_code >= `OP_SUB_BLOCK && op_code <= `OP_SYS_RUN) busy_q <= 1'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ones_low: assert property (take && op_code == `OP_ONES_LOW |=>
    acc == {$past(hi_w), ~$past(lo_w)} && op_done) else $error("ones complement wrong");
  a_neg_low: assert property (take && op_code == `OP_NEG_LOW |=>
    acc == {$past(hi_w), 16'h0000 - $past(lo_w)}) else $error("low negate wrong");
  a_neg_full: assert property (take && op_code == `OP_NEG_32 |=>
    acc == 32'h00000000 - $past(acc)) else $error("full negate wrong");
  a_byte_dec: assert property (take && op_code == `OP_DEC_BYTE |=>
    acc == {$past(mid_w), $past(byte_w) - $past(op_operand)}) else $error("decrement wrong");
  a_byte_inc: assert property (take && op_code == `OP_INC_BYTE |=>
    acc == {$past(mid_w), $past(byte_w) + $past(op_operand)}) else $error("increment wrong");
  a_fetch_start: assert property (take && op_code == `OP_SUB_BLOCK |=>
    fetch_req && fetch_space == 2'h0 && fetch_index == $past(op_operand))
    else $error("block word fetch wrong");
  a_subst_next: assert property (fetched_valid && fetch_req && !fetch_space[1] |=>
    subst_active && subst_value == $past(fetched_word)) else $error("substitution not held");
  a_marker_limit: assert property (take && op_code == `OP_SUB_MARKER && op_operand == 8'hFF
    |-> ##[1:3] op_error) else $error("marker word 255 accepted");
  a_sys_range: assert property (take && op_code == `OP_SYS_RUN &&
    (op_operand < 8'h3C || op_operand > 8'h3F) |-> ##[1:3] op_error) else $error("bad index run");
  a_mask_set: assert property (take && op_code == `OP_INT_MASK |=> irq_masked)
    else $error("mask not set");
  a_mask_hold: assert property (irq_masked && !(take && op_code == `OP_INT_UNMASK)
    |=> irq_masked) else $error("mask dropped");
  a_unmask_clr: assert property (take && op_code == `OP_INT_UNMASK |=> !irq_masked)
    else $error("unmask failed");
  a_irq_service: assert property (1'h1 |=>
    process_irq_service == $past(process_irq_req && !irq_masked)) else $error("service wrong");
  cover property (take && op_code == `OP_SYS_RUN);
  cover property ($rose(subst_active));
  cover property (irq_masked && process_irq_req);
endmodule // accu_convert_unit_props
bind accu_convert_unit accu_convert_unit_props accu_convert_unit_props_i (
  .clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op_code(op_code),
  .op_operand(op_operand), .fetched_word(fetched_word), .fetched_valid(fetched_valid),
  .process_irq_req(process_irq_req), .first_accumulator(first_accumulator),
  .op_done(op_done), .op_error(op_error), .fetch_req(fetch_req), .fetch_space(fetch_space),
  .fetch_index(fetch_index), .subst_active(subst_active), .subst_value(subst_value),
  .process_irq_service(process_irq_service), .irq_masked(irq_masked));
`default_nettype wire

// file: tb/tb_top.sv
/*
  self-checking bench for accu_convert_unit: table of accumulator ops, then
  substitution, indirect run and interrupt masking by hand.
  assumes the bench answers the first fetch one cycle after fetch_req, and a second fetch two cycles after its request.
*/
`timescale 1ns/10ps
`default_nettype none
`include "accu_consts.vh"
module tb_top;
  typedef struct {logic [4:0] op; logic [7:0] opd; logic [31:0] a; logic [31:0] e;} row_t;
  logic clk = 1'h0, reset_n = 1'h0, op_valid = 1'h0, logic_result = 1'h0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] op_operand = 8'h00;
  logic [2:0] op_kind = 3'h0;
  logic acc_load_valid = 1'h0, fetched_valid = 1'h0, process_irq_req = 1'h0;
  logic [31:0] acc_load_value = 32'h00000000;
  logic [15:0] fetched_word = 16'h0000, e0, e1;
  logic got_err, got_exec;
  wire [31:0] first_accumulator;
  wire op_done, op_error, fetch_req, subst_active, exec_valid, process_irq_service, irq_masked;
  wire [1:0] fetch_space;
  wire [7:0] fetch_index;
  wire [15:0] subst_value, exec_word0, exec_word1;
  wire [11:0] subst_byte_addr;
  wire [2:0] subst_bit_addr;
  integer fails = 0, checked = 0, i;
  row_t rows [18] = '{
    '{5'h01, 8'h00, 32'h12343E5B, 32'h1234C1A4}, '{5'h02, 8'h00, 32'hABCD0033, 32'hABCDFFCD},
    '{5'h03, 8'h00, 32'h00000001, 32'hFFFFFFFF}, '{5'h04, 8'h00, 32'h55559999, 32'h5555270F},
    '{5'h05, 8'h00, 32'hAAAA04D2, 32'hAAAA1234}, '{5'h06, 8'h00, 32'h12345678, 32'h00BC614E},
    '{5'h07, 8'h00, 32'h00BC614E, 32'h12345678}, '{5'h08, 8'h00, 32'h00000005, 32'h40A00000},
    '{5'h08, 8'h00, 32'hFFFFFFFD, 32'hC0400000}, '{5'h09, 8'h00, 32'h40B00000, 32'h00000005},
    '{5'h09, 8'h00, 32'hC0200000, 32'hFFFFFFFD}, '{5'h09, 8'h00, 32'hBF000000, 32'h00000000},
    '{5'h09, 8'h00, 32'h3F400000, 32'h00000000}, '{5'h09, 8'h00, 32'hBF800000, 32'hFFFFFFFF},
    '{5'h0A, 8'h10, 32'h12340005, 32'h123400F5}, '{5'h0A, 8'hFF, 32'h000010FF, 32'h00001000},
    '{5'h0B, 8'h10, 32'h00001010, 32'h00001020}, '{5'h0B, 8'h01, 32'h000010FF, 32'h00001000}};
  always #20 clk = ~clk;
  accu_convert_unit accu_convert_unit_i (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .op_operand(op_operand), .op_param(16'h0000), .op_kind(op_kind),
    .logic_result(logic_result), .acc_load_valid(acc_load_valid),
    .acc_load_value(acc_load_value), .fetched_word(fetched_word),
    .fetched_valid(fetched_valid), .process_irq_req(process_irq_req),
    .first_accumulator(first_accumulator), .op_done(op_done), .op_error(op_error),
    .fetch_req(fetch_req), .fetch_space(fetch_space), .fetch_index(fetch_index),
    .subst_active(subst_active), .subst_value(subst_value), .subst_byte_addr(subst_byte_addr),
    .subst_bit_addr(subst_bit_addr), .exec_valid(exec_valid), .exec_word0(exec_word0),
    .exec_word1(exec_word1), .process_irq_service(process_irq_service),
    .irq_masked(irq_masked));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task load(input logic [31:0] v);
    @(negedge clk); acc_load_valid = 1'h1; acc_load_value = v;
    @(negedge clk); acc_load_valid = 1'h0;
  endtask
  task do_op(input logic [4:0] c, input logic [7:0] o);
    @(negedge clk); op_valid = 1'h1; op_code = c; op_operand = o;
    @(negedge clk); op_valid = 1'h0;
  endtask
  // answers fetches with {hi, index} so the index shows in the word
  task serve(input logic [7:0] hi);
    integer n;
    n = 0; got_exec = 1'h0;
    while (!(op_done || op_error) && n < 20) begin
      if (exec_valid) begin e0 = exec_word0; e1 = exec_word1; got_exec = 1'h1; end
      if (fetch_req && !fetched_valid) begin
        fetched_valid = 1'h1; fetched_word = {hi, fetch_index};
      end else fetched_valid = 1'h0;
      @(negedge clk); n = n + 1;
    end
    if (exec_valid) begin e0 = exec_word0; e1 = exec_word1; got_exec = 1'h1; end
    got_err = op_error; fetched_valid = 1'h0;
    if (n >= 20) begin fails = fails + 1; $display("FAIL %0t op never finished", $time); end
  endtask
  task msub(input logic [2:0] k, input logic [7:0] hi, input logic [7:0] o,
            input logic [11:0] eb, input logic [2:0] ebit, input logic eerr);
    op_kind = k; do_op(`OP_SUB_MARKER, o); serve(hi);
    chk(got_err, eerr, "marker error");
    if (!eerr) chk(subst_value, {hi, o}, "marker value");
    if (!eerr && k != 3'h0) chk(subst_byte_addr, eb, "byte addr");
    if (!eerr && (k == 3'h1 || k == 3'h2)) chk(subst_bit_addr, ebit, "bit addr");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(40 * 3000);
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    repeat (12) @(negedge clk);
    chk(first_accumulator, 32'h00000000, "reset acc");
    chk({op_done, irq_masked, subst_active}, 3'h0, "reset flags");
    reset_n = 1'h1;
    for (i = 0; i < 18; i = i + 1) begin
      load(rows[i].a); logic_result = i[0];
      do_op(rows[i].op, rows[i].opd);
      chk(first_accumulator, rows[i].e, "acc op");
      chk(op_done, 1'h1, "done");
    end
    $display("test table done");
    op_kind = 3'h0; do_op(`OP_SUB_BLOCK, 8'hC8); serve(8'h12);
    chk({subst_active, subst_value}, 17'h112C8, "block subst");
    do_op(`OP_INC_BYTE, 8'h01); @(negedge clk);
    chk(subst_active, 1'h0, "subst cleared");
    msub(3'h1, 8'hFA, 8'hBC, 12'h0BC, 3'h2, 1'h0);
    msub(3'h2, 8'h7A, 8'hBC, 12'hABC, 3'h7, 1'h0);
    msub(3'h2, 8'hFA, 8'hBC, 12'h000, 3'h0, 1'h1);
    msub(3'h3, 8'hFF, 8'h12, 12'h012, 3'h0, 1'h0);
    msub(3'h0, 8'h00, 8'hFE, 12'h000, 3'h0, 1'h0);
    msub(3'h0, 8'h00, 8'hFF, 12'h000, 3'h0, 1'h1);
    $display("test substitution done");
    for (i = 0; i < 5; i = i + 1) begin
      op_kind = i[2:0]; do_op(`OP_SUB_FORMAL, 8'h05); serve(8'h00);
      chk(got_err, i != 4, "formal kind");
    end
    load(32'h00000003);
    do_op(`OP_FORMAL_RUN, 8'h00);
    chk({fetch_req, fetch_space, fetch_index}, 11'h603, "formal fetch");
    serve(8'h4A);
    chk({got_exec, e0}, 17'h14A03, "formal run");
    do_op(`OP_SYS_RUN, 8'h3C);
    chk({fetch_req, fetch_space, fetch_index}, 11'h73C, "system fetch");
    serve(8'h4A);
    chk({got_exec, e0}, 17'h14A3C, "system run");
    chk(e1, 16'h4A3D, "system run second");
    do_op(`OP_SYS_RUN, 8'h3F); serve(8'h4A);
    chk({got_exec, e0}, 17'h14A3F, "system run last");
    do_op(`OP_SYS_RUN, 8'h3B); serve(8'h4A);
    chk(got_err, 1'h1, "index 59");
    do_op(`OP_SYS_RUN, 8'h40); serve(8'h4A);
    chk(got_err, 1'h1, "index 64");
    $display("test indirect run done");
    process_irq_req = 1'h1; repeat (2) @(negedge clk);
    chk(process_irq_service, 1'h1, "service open");
    do_op(`OP_INT_MASK, 8'h00); repeat (4) @(negedge clk);
    chk({irq_masked, process_irq_service}, 2'h2, "masked");
    do_op(`OP_INT_UNMASK, 8'h00); repeat (2) @(negedge clk);
    chk({irq_masked, process_irq_service}, 2'h1, "unmasked");
    process_irq_req = 1'h0;
    $display("test interrupt mask done");
    do_op(`OP_INT_MASK, 8'h00);
    reset_n = 1'h0;
    @(negedge clk);
    chk(first_accumulator, 32'h00000000, "mid reset acc");
    chk({irq_masked, op_done}, 2'h0, "mid reset flags");
    reset_n = 1'h1;
    do_op(`OP_INC_BYTE, 8'h05);
    chk(first_accumulator, 32'h00000005, "after reset");
    $display("test mid reset done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
